//--- pci_status_pkg.sv
// constants for the pci bus-event status register
package pci_status_pkg;
    // configuration offset and width
    localparam logic [7:0] status_offset = 8'h06;
    localparam int status_width = 16;
    // bit positions of the event flags
    localparam int parity_error_seen_bit = 15;
    localparam int system_error_signalled_bit = 14;
    localparam int master_abort_received_bit = 13;
    localparam int target_abort_received_bit = 12;
    localparam int target_abort_signalled_bit = 11;
    localparam int master_parity_error_flag_bit = 8;
    // bit positions of the fixed fields
    localparam int decode_speed_lsb = 9;
    localparam int back_to_back_capable_bit = 7;
    localparam int high_freq_capable_bit = 5;
    localparam int capability_list_present_bit = 4;
    // number of sticky event flags and their index in the flag bank
    localparam int num_flags = 6;
    localparam int idx_master_parity_error_flag = 0;
    localparam int idx_sta = 1;
    localparam int idx_rta = 2;
    localparam int idx_rma = 3;
    localparam int idx_sse = 4;
    localparam int idx_dpe = 5;
    // decode speed encodings, 2'h3 is never reported
    typedef enum logic [1:0] {
        speed_fast = 2'h0,
        speed_medium = 2'h1,
        speed_slow = 2'h2
    } decode_speed_t;
    // fixed capability values
    localparam decode_speed_t decode_speed_field = speed_medium;
    localparam logic back_to_back_capable = 1'h0;
    localparam logic high_freq_capable = 1'h0;
    localparam logic capability_list_present = 1'h1;
    // whole-register reset value: medium speed and capability list
    localparam logic [15:0] status_reset = 16'h0210;
    // read data for a non-matching offset
    localparam logic [15:0] rdata_idle = 16'h0000;
endpackage

//--- event_flag_bank.sv
// bank of sticky event flags, set by pulses, cleared only by reset
module event_flag_bank #(
    parameter int n = 6
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // set pulses
    input wire logic [n-1:0] i_set,
    // flag levels
    output logic [n-1:0] o_flag
);
    // one flop per flag
    genvar g;
    generate
        for (g = 0; g < n; g++) begin : g_flag
            // sticky: once set only reset clears it
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_flag[g] <= 1'h0;
                end else if (i_ce && i_set[g]) begin
                    o_flag[g] <= 1'h1;
                end
            end
        end
    endgenerate
endmodule

//--- pci_config_status_register.sv
// pci configuration status register with sticky bus-event flags
// Functional notes
// R1 - 16-bit read-only register at offset 06h
// R2 - bit 15 sets on any parity error
// R3 - bit 14 sets whenever system error driven
// R4 - bit 13 master abort, special cycles excluded
// R5 - bit 12 sets on received target abort
// R6 - bit 11 sets when target abort signalled
// R7 - decode speed 00 fast, 01 medium, 10 slow
// R8 - bits 10:9 slowest speed, reset medium
// R9 - bit 8 needs master, perr, parity response
// R10 - bit 7 reads zero, no back-to-back
// R11 - bit 5 reads zero, 33 MHz only
// R12 - bit 4 reads one, capability list present
// R13 - flags reset zero, reserved bits read zero
// R14 - configuration writes change no bit
module pci_config_status_register (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // configuration access from the bus target logic
    input wire logic i_cfg_rd,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [15:0] i_cfg_wdata,
    // bus events from the pci core, one-cycle pulses
    input wire logic i_parity_error_detected,
    input wire logic i_system_error_driven,
    input wire logic i_master_abort,
    input wire logic i_special_cycle,
    input wire logic i_target_abort_received,
    input wire logic i_target_abort_signalled,
    input wire logic i_master_active,
    input wire logic i_perr_driven_on_read,
    input wire logic i_perr_seen_on_write,
    // command register parity response bit
    input wire logic i_parity_response_enable,
    // read answer
    output logic [15:0] o_cfg_rdata,
    output logic o_cfg_rvalid
);
    // flag set conditions
    logic [pci_status_pkg::num_flags-1:0] set_vec;
    logic [pci_status_pkg::num_flags-1:0] flag;
    // assembled register word
    logic [15:0] status_word;
    // offset decode
    wire addr_hit = (i_cfg_addr == pci_status_pkg::status_offset); // [R1]
    wire rd_hit = i_cfg_rd && addr_hit;
    // master data parity: all three conditions together
    wire master_parity_error_flag_cond = i_master_active && (i_perr_driven_on_read || i_perr_seen_on_write)
        && i_parity_response_enable; // [R9]
    // master abort only for non special-cycle transactions
    wire rma_cond = i_master_abort && !i_special_cycle; // [R4]

    // set vector in flag-bank order
    assign set_vec[pci_status_pkg::idx_dpe] = i_parity_error_detected; // [R2]
    assign set_vec[pci_status_pkg::idx_sse] = i_system_error_driven; // [R3]
    assign set_vec[pci_status_pkg::idx_rma] = rma_cond; // [R4]
    assign set_vec[pci_status_pkg::idx_rta] = i_target_abort_received; // [R5]
    assign set_vec[pci_status_pkg::idx_sta] = i_target_abort_signalled; // [R6]
    assign set_vec[pci_status_pkg::idx_master_parity_error_flag] = master_parity_error_flag_cond; // [R9]

    // sticky flags; no write path reaches them
    event_flag_bank #(
        .n(pci_status_pkg::num_flags)
    ) u_flags (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_set(set_vec),
        .o_flag(flag)
    ); // [R14]

    // word assembly: flags, fixed fields, reserved zeros
    always_comb begin
        status_word = 16'h0000; // [R13]
        status_word[pci_status_pkg::parity_error_seen_bit] = flag[pci_status_pkg::idx_dpe];
        status_word[pci_status_pkg::system_error_signalled_bit] = flag[pci_status_pkg::idx_sse];
        status_word[pci_status_pkg::master_abort_received_bit] = flag[pci_status_pkg::idx_rma];
        status_word[pci_status_pkg::target_abort_received_bit] = flag[pci_status_pkg::idx_rta];
        status_word[pci_status_pkg::target_abort_signalled_bit] = flag[pci_status_pkg::idx_sta];
        status_word[pci_status_pkg::master_parity_error_flag_bit] =
            flag[pci_status_pkg::idx_master_parity_error_flag];
        // decode speed field, medium and never 2'h3
        status_word[pci_status_pkg::decode_speed_lsb +: 2] =
            pci_status_pkg::decode_speed_field; // [R7] [R8]
        status_word[pci_status_pkg::back_to_back_capable_bit] =
            pci_status_pkg::back_to_back_capable; // [R10]
        status_word[pci_status_pkg::high_freq_capable_bit] =
            pci_status_pkg::high_freq_capable; // [R11]
        status_word[pci_status_pkg::capability_list_present_bit] =
            pci_status_pkg::capability_list_present; // [R12]
    end

    // read answer, one cycle after the request; writes are ignored
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_rdata <= pci_status_pkg::rdata_idle;
            o_cfg_rvalid <= 1'h0;
        end else if (i_ce) begin
            o_cfg_rvalid <= rd_hit; // [R1]
            o_cfg_rdata <= rd_hit ? status_word : pci_status_pkg::rdata_idle;
        end
    end

    // assertions on the flag word and the read answer
    // an event pulse with the clock enabled
    sequence s_evt(logic e);
        i_ce && e;
    endsequence
    // a flag seen high in the following cycle
    sequence s_high(logic f);
        ##1 f;
    endsequence

    // any parity error sets bit 15
    property p_dpe_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_evt(i_parity_error_detected) |-> s_high(status_word[15]);
    endproperty
    a_dpe_set: assert property (p_dpe_set) else $error("parity flag not set"); // [R2]

    // driving the system error line sets bit 14
    property p_sse_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_evt(i_system_error_driven) |-> s_high(status_word[14]);
    endproperty
    a_sse_set: assert property (p_sse_set) else $error("system error flag not set"); // [R3]

    // a special-cycle master abort leaves bit 13 alone
    property p_rma_special;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!status_word[13] && !(i_master_abort && !i_special_cycle)) |=> !status_word[13];
    endproperty
    a_rma_special: assert property (p_rma_special) else $error("master abort set wrongly"); // [R4]

    // an ordinary master abort sets bit 13
    property p_rma_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_evt(i_master_abort && !i_special_cycle) |-> s_high(status_word[13]);
    endproperty
    a_rma_set: assert property (p_rma_set) else $error("master abort flag not set"); // [R4]

    // both abort flags follow their own pulses
    property p_rta_sta_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && (i_target_abort_received || i_target_abort_signalled) |=>
            (status_word[12] || !$past(i_target_abort_received))
            && (status_word[11] || !$past(i_target_abort_signalled));
    endproperty
    a_rta_sta_set: assert property (p_rta_sta_set) else $error("abort flag not set"); // [R5]

    // no master parity flag without master and response enable
    property p_master_parity_error_flag_gate;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!status_word[8] && !(i_master_active && i_parity_response_enable)) |=>
            !status_word[8];
    endproperty
    a_master_parity_error_flag_gate: assert property (p_master_parity_error_flag_gate) else $error("master parity flag ungated"); // [R9]

    // all three conditions together set bit 8
    property p_master_parity_error_flag_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_evt(i_master_active && (i_perr_driven_on_read || i_perr_seen_on_write)
            && i_parity_response_enable) |-> s_high(status_word[8]);
    endproperty
    a_master_parity_error_flag_set: assert property (p_master_parity_error_flag_set) else $error("master parity flag not set"); // [R9]

    // fixed fields hold their constant values
    property p_fixed_bits;
        @(posedge i_clk) disable iff (!i_rst_n)
        status_word[10:9] == 2'h1 && status_word[7:4] == 4'h1 && status_word[3:0] == 4'h0;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong"); // [R8]

    // reserved bits stay zero, decode code 2'h3 never shows
    property p_reserved_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        status_word[6] == 1'h0 && status_word[3:0] == 4'h0 && status_word[10:9] != 2'h3;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [R13]

    // a write never alters the word, only events do
    property p_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_cfg_wr |=> (status_word & 16'hF900) == ($past(status_word) & 16'hF900)
            || (|$past(set_vec));
    endproperty
    a_sticky: assert property (p_sticky) else $error("write altered status"); // [R14]

    // flags and read answer are clear while reset is low
    property p_reset_clear;
        @(posedge i_clk)
        !i_rst_n |=> (status_word & 16'hF900) == 16'h0000
            && !o_cfg_rvalid && o_cfg_rdata == pci_status_pkg::rdata_idle;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("flags not clear in reset"); // [R13]

    // a low enable freezes the flags and the read answer
    property p_ce_freeze;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_ce |=> $stable(flag) && $stable(o_cfg_rvalid) && $stable(o_cfg_rdata);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("enable low did not freeze"); // [R14]

    // a read hit answers with the word of its own edge
    property p_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && rd_hit |=>
            o_cfg_rvalid && o_cfg_rdata == $past(status_word);
    endproperty
    a_read: assert property (p_read) else $error("read answer wrong"); // [R1]

    // no hit, no answer and idle read data
    property p_no_answer;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !rd_hit |=>
            !o_cfg_rvalid && o_cfg_rdata == pci_status_pkg::rdata_idle;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without read hit"); // [R1]
endmodule

//--- config_host.sv
// configuration-access master standing in for the host bridge
module config_host (
    // configuration access
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 16'h0000;
    end
    // one access cycle, called just after a falling edge
    task put(input logic rd, input logic wr, input logic [7:0] a, input logic [15:0] d);
        o_rd = rd;
        o_wr = wr;
        o_addr = a;
        o_wdata = d;
    endtask
endmodule

//--- testbench.sv
// self-checking bench for the pci status register
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, i_cfg_rd, i_cfg_wr, o_cfg_rvalid;
    logic [7:0] i_cfg_addr, a;
    logic [15:0] i_cfg_wdata, o_cfg_rdata;
    logic [8:0] ev; // pe, serr, ma, tar, tas, special, master, perr rd, perr wr
    logic parity_response_enable; // parity response enable
    logic [15:0] model; // expected register word
    logic [15:0] expq[$]; // pending read answers
    logic ce, held_valid; // clock enable, answer standing in the register
    logic [15:0] held_word; // read data standing in the register
    int miscompares, checks, seed;
    // far-side access master
    config_host host (.o_rd(i_cfg_rd), .o_wr(i_cfg_wr), .o_addr(i_cfg_addr),
        .o_wdata(i_cfg_wdata));
    pci_config_status_register dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr),
        .i_cfg_wdata(i_cfg_wdata), .i_parity_error_detected(ev[8]),
        .i_system_error_driven(ev[7]), .i_master_abort(ev[6]), .i_special_cycle(ev[3]),
        .i_target_abort_received(ev[5]), .i_target_abort_signalled(ev[4]),
        .i_master_active(ev[2]), .i_perr_driven_on_read(ev[1]),
        .i_perr_seen_on_write(ev[0]), .i_parity_response_enable(parity_response_enable),
        .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid));
    // 100 ns clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // verdict and end of run
    task results();
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // word compare
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reset pulse of four cycles, bus idle around it
    task rst();
        @(negedge i_clk);
        ev = 9'h000;
        ce = 1'b1;
        host.put(1'b0, 1'b0, 8'h00, 16'h0000);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        held_valid = 1'b0;
        held_word = pci_status_pkg::rdata_idle;
        model = pci_status_pkg::status_reset; // medium speed, list present, flags clear
    endtask
    // one cycle of events and access; a read notes the word before this edge
    task step(input logic [8:0] e, input logic p, input logic rd, input logic wr,
        input logic [7:0] ad, input logic c);
        @(negedge i_clk);
        ev = e;
        parity_response_enable = p;
        ce = c;
        host.put(rd, wr, ad, 16'($random(seed)));
        // enable low: nothing taken, the last answer stands once more
        if (c) begin
            held_valid = rd && ad == pci_status_pkg::status_offset;
            held_word = held_valid ? model : pci_status_pkg::rdata_idle;
            model[15:11] = model[15:11] | (e[8:4] & {2'b11, ~e[3], 2'b11});
            model[8] = model[8] | (e[2] & (e[1] | e[0]) & p);
        end
        if (held_valid) expq.push_back(held_word);
    endtask
    // answer watcher: every valid pops the oldest note
    always @(negedge i_clk) begin
        if (o_cfg_rvalid !== 1'b0) begin
            if (expq.size() == 0) cmp(16'(o_cfg_rvalid), 16'h0000);
            else cmp(o_cfg_rdata, expq.pop_front());
        end else begin
            cmp(o_cfg_rdata, pci_status_pkg::rdata_idle);
        end
    end
    // hang guard
    initial begin
        repeat (3000) @(posedge i_clk);
        miscompares++;
        results();
    end
    // main sequence
    initial begin
        seed = 32'hc21b;
        miscompares = 0;
        checks = 0;
        i_rst_n = 1'b0;
        ev = 9'h000;
        parity_response_enable = 1'b0;
        ce = 1'b1;
        held_valid = 1'b0;
        rst();
        // reset word, then refused events and parity error with response off
        step(9'h000, 1'b0, 1'b1, 1'b0, 8'h06, 1'b1);
        step(9'h048, 1'b1, 1'b1, 1'b0, 8'h06, 1'b1);
        step(9'h006, 1'b0, 1'b1, 1'b0, 8'h06, 1'b1);
        step(9'h003, 1'b1, 1'b1, 1'b1, 8'h06, 1'b1);
        step(9'h100, 1'b0, 1'b1, 1'b1, 8'h06, 1'b1);
        step(9'h000, 1'b0, 1'b1, 1'b0, 8'h06, 1'b1);
        // enable low: event and read held off, answer frozen
        step(9'h010, 1'b0, 1'b1, 1'b0, 8'h06, 1'b0);
        step(9'h000, 1'b0, 1'b1, 1'b0, 8'h06, 1'b1);
        // every event but the parity error at once with its conditions met
        step(9'h0f6, 1'b1, 1'b1, 1'b0, 8'h06, 1'b1);
        step(9'h000, 1'b0, 1'b1, 1'b0, 8'h06, 1'b1);
        // sparse random events, writes and stray offsets
        repeat (8) begin
            rst();
            repeat (14) begin
                a = (($random(seed) & 3) != 0) ? 8'h06 : 8'($random(seed));
                step(9'($random(seed) & $random(seed) & $random(seed)), 1'($random(seed)),
                    1'($random(seed)), 1'($random(seed)), a, 1'(($random(seed) & 7) != 0));
            end
        end
        step(9'h000, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
        repeat (2) @(negedge i_clk);
        cmp(16'(expq.size()), 16'h0000);
        results();
    end
endmodule
